// >>> inc/data_move_cfg.svh
`ifndef DATA_MOVE_CFG_SVH
`define DATA_MOVE_CFG_SVH

// Opcode fields of the four data-move instructions.
`define OPC_COPY_FIRST 4'hc
`define OPC_COPY_SECOND 4'hf
`define OPC_LOAD_BANK 8'h01
`define OPC_LOAD_LIT 8'h0e
`define OPC_STORE_ACC 7'h37

// Field positions within an instruction word.
`define FLD_NIBBLE_HI 15
`define FLD_NIBBLE_LO 12
`define FLD_BYTE_LO 8
`define FLD_STORE_LO 9
`define FLD_ACCESS_BIT 8

// Data-space location of the working register and access bank layout.
`define ACCUM_ADDR 12'hfe8
`define ACCESS_SPLIT 8'h80
`define ACCESS_HI_BANK 4'hf
`define ACCESS_LO_BANK 4'h0

// Quarter phases of one instruction cycle.
`define PH_Q1 2'h0
`define PH_Q2 2'h1
`define PH_Q3 2'h2
`define PH_Q4 2'h3

// Reset values.
`define RST_ACCUM 8'h00
`define RST_BANK 8'h00

`endif

// >>> inc/data_move_pkg.sv
package data_move_pkg;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_WAIT_DEST = 1'b1
  } seq_state_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_COPY_READ = 3'b001,
    OP_COPY_WRITE = 3'b010,
    OP_LOAD_BANK = 3'b011,
    OP_LOAD_LIT = 3'b100,
    OP_STORE = 3'b101
  } move_op_t;

  typedef struct packed {
    logic rd_en;
    logic wr_en;
    logic [11:0] addr;
    logic [7:0] wdata;
  } mem_req_t;

  typedef struct packed {
    seq_state_t st;
    logic [1:0] phase;
    move_op_t op;
    logic [15:0] instr;
    logic [11:0] dest;
    logic [7:0] data;
    logic [7:0] accum;
    logic [7:0] bank;
    logic bad_second;
    mem_req_t mem;
  } move_state_t;

endpackage : data_move_pkg

// >>> hdl/data_move_instruction_group.sv
`timescale 1ns/1ps
`default_nettype none
`include "data_move_cfg.svh"

// What this block does
// - Decode two-word copy: first word 1100 plus source, second 1111 plus destination.
// - Copy addresses span the whole 4096-byte data space with no bank selection.
// - Copy writes source value to destination; source and status flags untouched.
// - The working register may be copy source or destination like any location.
// - Copy takes two words and two cycles, one more for each cycle the second word is late.
// - Opcode byte 0000 0001 loads the literal into the bank select register.
// - Opcode byte 0000 1110 loads the literal into the working register in one cycle.
// - Upper bits 0110 111a store the working register to a file location.
// - Access bit zero picks the access bank; one picks the selected 256-byte bank.
module data_move_instruction_group
  import data_move_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_instr_valid,
  input wire logic [15:0] i_instr,
  input wire logic [7:0] i_mem_rdata,
  output logic o_instr_taken,
  output logic o_copy_pending,
  output logic o_bad_second,
  output logic [1:0] o_phase,
  output mem_req_t o_mem,
  output logic [7:0] o_accum,
  output logic [7:0] o_bank
);

  if (ADDR_W != 12) begin : g_check_width
    $error("data_move_instruction_group serves a 12-bit data space only");
  end

  move_state_t s_q;
  move_state_t s_d;
  logic is_copy_first;
  logic is_copy_second;
  logic is_load_bank;
  logic is_load_lit;
  logic is_store;
  logic at_q1;

  // True when a data-space address names the working register.
  function automatic logic is_accum_addr(input logic [11:0] addr);
    is_accum_addr = (addr == `ACCUM_ADDR);
  endfunction : is_accum_addr

  // Banked file address of a single-word instruction.
  function automatic logic [11:0] file_addr(input logic [15:0] instr, input logic [7:0] bank);
    logic [7:0] f;
    f = instr[7:0];
    if (!instr[`FLD_ACCESS_BIT]) begin
      if (f < `ACCESS_SPLIT) begin
        file_addr = {`ACCESS_LO_BANK, f};
      end else begin
        file_addr = {`ACCESS_HI_BANK, f};
      end
    end else begin
      file_addr = {bank[3:0], f};
    end
  endfunction : file_addr

  assign at_q1 = (s_q.phase == `PH_Q1);
  assign is_copy_first = (i_instr[`FLD_NIBBLE_HI:`FLD_NIBBLE_LO] == `OPC_COPY_FIRST);
  assign is_copy_second = (i_instr[`FLD_NIBBLE_HI:`FLD_NIBBLE_LO] == `OPC_COPY_SECOND);
  assign is_load_bank = (i_instr[15:`FLD_BYTE_LO] == `OPC_LOAD_BANK);
  assign is_load_lit = (i_instr[15:`FLD_BYTE_LO] == `OPC_LOAD_LIT);
  assign is_store = (i_instr[15:`FLD_STORE_LO] == `OPC_STORE_ACC);

  always_comb begin
    s_d = s_q;
    s_d.phase = s_q.phase + 2'h1;
    s_d.bad_second = 1'b0;
    s_d.mem.rd_en = 1'b0;
    s_d.mem.wr_en = 1'b0;
    o_instr_taken = 1'b0;
    case (s_q.phase)
      `PH_Q1: begin
        if (i_instr_valid) begin
          case (s_q.st)
            ST_IDLE: begin
              s_d.instr = i_instr;
              if (is_copy_first) begin
                o_instr_taken = 1'b1;
                s_d.op = OP_COPY_READ;
                s_d.st = ST_WAIT_DEST;
                s_d.mem.addr = i_instr[11:0];
                s_d.mem.rd_en = !is_accum_addr(i_instr[11:0]);
              end else if (is_load_bank) begin
                o_instr_taken = 1'b1;
                s_d.op = OP_LOAD_BANK;
              end else if (is_load_lit) begin
                o_instr_taken = 1'b1;
                s_d.op = OP_LOAD_LIT;
              end else if (is_store) begin
                o_instr_taken = 1'b1;
                s_d.op = OP_STORE;
              end else begin
                s_d.op = OP_NONE;
              end
            end
            ST_WAIT_DEST: begin
              o_instr_taken = 1'b1;
              s_d.st = ST_IDLE;
              if (is_copy_second) begin
                s_d.op = OP_COPY_WRITE;
                s_d.dest = i_instr[11:0];
              end else begin
                s_d.op = OP_NONE;
                s_d.bad_second = 1'b1;
              end
            end
            default: begin
              s_d.st = ST_IDLE;
            end
          endcase
        end else if (s_q.st == ST_IDLE) begin
          s_d.op = OP_NONE;
        end else begin
          // A late second word stretches the copy by a whole cycle.
          s_d.op = OP_NONE;
        end
      end
      `PH_Q2: begin
        if (s_q.op == OP_COPY_READ) begin
          if (is_accum_addr(s_q.mem.addr)) begin
            s_d.data = s_q.accum;
          end else begin
            s_d.data = i_mem_rdata;
          end
        end
      end
      `PH_Q3: begin
        if (s_q.op == OP_COPY_WRITE && !is_accum_addr(s_q.dest)) begin
          s_d.mem.wr_en = 1'b1;
          s_d.mem.addr = s_q.dest;
          s_d.mem.wdata = s_q.data;
        end else if (s_q.op == OP_STORE) begin
          s_d.mem.wr_en = 1'b1;
          s_d.mem.addr = file_addr(s_q.instr, s_q.bank);
          s_d.mem.wdata = s_q.accum;
        end
      end
      `PH_Q4: begin
        case (s_q.op)
          OP_COPY_WRITE: begin
            if (is_accum_addr(s_q.dest)) begin
              s_d.accum = s_q.data;
            end
          end
          OP_LOAD_BANK: begin
            s_d.bank = s_q.instr[7:0];
          end
          OP_LOAD_LIT: begin
            s_d.accum = s_q.instr[7:0];
          end
          default: begin
          end
        endcase
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.op <= OP_NONE;
      s_q.phase <= `PH_Q1;
      s_q.accum <= `RST_ACCUM;
      s_q.bank <= `RST_BANK;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_copy_pending = (s_q.st == ST_WAIT_DEST);
  assign o_bad_second = s_q.bad_second;
  assign o_phase = s_q.phase;
  assign o_mem = s_q.mem;
  assign o_accum = s_q.accum;
  assign o_bank = s_q.bank;

endmodule : data_move_instruction_group
`default_nettype wire

// >>> bench/data_move_sva.sv
`timescale 1ns/1ps
`default_nettype none
module data_move_sva
  import data_move_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_instr_valid,
  input wire logic [15:0] i_instr,
  input wire logic [7:0] i_mem_rdata,
  input wire logic o_instr_taken,
  input wire logic o_copy_pending,
  input wire logic o_bad_second,
  input wire logic [1:0] o_phase,
  input wire mem_req_t o_mem,
  input wire logic [7:0] o_accum,
  input wire logic [7:0] o_bank
);
  logic q1;
  logic q2;
  assign q1 = o_phase == 2'h0 && i_instr_valid && !o_copy_pending;
  assign q2 = o_phase == 2'h0 && i_instr_valid && o_copy_pending;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  bank_load_a: assert property (q1 && i_instr[15:8] == 8'h01
    |=> ##3 o_bank == $past(i_instr[7:0], 4)) else $error("bank load");
  lit_load_a: assert property (q1 && i_instr[15:8] == 8'h0e
    |=> ##3 o_accum == $past(i_instr[7:0], 4)) else $error("literal load");
  lit_taken_a: assert property (q1 && i_instr[15:8] == 8'h0e |-> o_instr_taken)
    else $error("not taken");
  src_read_a: assert property (q1 && i_instr[15:12] == 4'hc && i_instr[11:0] != 12'hfe8
    |=> o_mem.rd_en && o_mem.addr == $past(i_instr[11:0])) else $error("source read");
  dst_write_a: assert property (q2 && i_instr[15:12] == 4'hf |=> !o_mem.rd_en ##2
    o_mem.wr_en == ($past(i_instr[11:0], 3) != 12'hfe8)) else $error("dest write");
  bad_word_a: assert property (q2 && i_instr[15:12] != 4'hf
    |=> o_bad_second && !o_copy_pending ##2 !o_mem.wr_en) else $error("bad second");
  store_wr_a: assert property (q1 && i_instr[15:9] == 7'h37 && i_instr[8]
    |=> ##2 o_mem.wr_en && o_mem.wdata == o_accum) else $error("store");
  wr_pulse_a: assert property (o_mem.wr_en |=> !o_mem.wr_en)
    else $error("write pulse");
endmodule : data_move_sva
bind data_move_instruction_group data_move_sva u_sva (.i_clk(i_clk), .i_rst(i_rst),
  .i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_mem_rdata(i_mem_rdata),
  .o_instr_taken(o_instr_taken), .o_copy_pending(o_copy_pending),
  .o_bad_second(o_bad_second), .o_phase(o_phase), .o_mem(o_mem), .o_accum(o_accum),
  .o_bank(o_bank));
`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import data_move_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_instr_valid = 1'b0;
  logic [15:0] i_instr = 16'h0000;
  logic [7:0] i_mem_rdata;
  logic o_instr_taken, o_copy_pending, o_bad_second;
  logic [1:0] o_phase;
  mem_req_t o_mem;
  logic [7:0] o_accum, o_bank;
  logic [7:0] mem [4096];
  int n_errors = 0;
  int total_checks = 0;
  assign i_mem_rdata = mem[o_mem.addr];
  always @(posedge i_clk) if (o_mem.wr_en === 1'b1) mem[o_mem.addr] <= o_mem.wdata;
  data_move_instruction_group u_data_move_instruction_group (.i_clk(i_clk), .i_rst(i_rst),
    .i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_mem_rdata(i_mem_rdata),
    .o_instr_taken(o_instr_taken), .o_copy_pending(o_copy_pending),
    .o_bad_second(o_bad_second), .o_phase(o_phase), .o_mem(o_mem), .o_accum(o_accum),
    .o_bank(o_bank));
  initial begin
    forever #12.5 i_clk = ~i_clk;
  end
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk) #1;
  endtask : tick
  // Presents one word in the next Q1 clock.
  task automatic word(input logic [15:0] w);
    int k;
    for (k = 0; k < 8 && o_phase !== 2'h0; k++) tick(1);
    if (k == 8) begin
      n_errors++;
      close_out;
    end
    i_instr = w;
    i_instr_valid = 1'b1;
    #1 chk({7'h00, o_instr_taken}, 8'h01);
    tick(1);
    i_instr_valid = 1'b0;
  endtask : word
  initial begin
    for (int a = 0; a < 4096; a++) mem[a] = a[7:0] ^ 8'h5a;
    repeat (16) @(posedge i_clk);
    #1 i_rst = 1'b0;
    word(16'h0e3c);
    word(16'h0105);
    tick(4);
    chk(o_accum, 8'h3c);
    chk(o_bank, 8'h05);
    word(16'h6f21);
    word(16'h6e90);
    word(16'h6e10);
    tick(4);
    chk(mem[12'h521], 8'h3c);
    chk(mem[12'hf90], 8'h3c);
    chk(mem[12'h010], 8'h3c);
    word(16'hc000);
    word(16'hffff);
    tick(8);
    chk(mem[12'hfff], 8'h5a);
    chk(mem[12'h000], 8'h5a);
    word(16'hc123);
    chk({7'h00, o_copy_pending}, 8'h01);
    tick(4);
    // Destinations stay clear of the counter and stack top bytes.
    word(16'hf456);
    tick(8);
    chk(mem[12'h456], 8'h79);
    word(16'hcfe8);
    word(16'hf200);
    tick(8);
    chk(mem[12'h200], 8'h3c);
    word(16'hc300);
    word(16'hffe8);
    tick(8);
    chk(o_accum, 8'h5a);
    word(16'hc400);
    word(16'h0e77);
    chk({7'h00, o_bad_second}, 8'h01);
    chk({7'h00, o_copy_pending}, 8'h00);
    tick(8);
    chk(o_accum, 8'h5a);
    close_out;
  end
endmodule : tb_top
`default_nettype wire
